// ===== verilog/nsr_store_recall_ctrl.v
// How it works
// - A power-loss or pin store is skipped when no SRAM write happened since the last transfer.
// - After a transfer starts, SRAM access stays enabled for at most 25 ns, then drops.
// - SRAM reads and writes are ignored during store or recall and while the supply is low.
// - After the supply rises above the trip level, the power-up restore ends within 20 ms.
// - The SRAM is disabled while the host holds the busy pin low.
// - Serial activity is locked out until a running store or recall has finished.
// - A serial store or recall command is acted on within 100 us of being accepted.
// - A pin store with no pending write leaves the pin undriven within 25 ns.
// - A busy status bit shows whether a store or recall is in progress.
// - After a store the pin is driven high for at most 500 ns and then released.
`include "nsr_store_recall_map.vh"
`timescale 1ns/1ps
`default_nettype none

module nsr_store_recall_ctrl #(
   parameter [`NSR_CNT_W-1:0] STORE_CYC = `NSR_STORE_CYC,
   parameter [`NSR_CNT_W-1:0] PUP_CYC = `NSR_PUP_CYC,
   parameter [`NSR_CNT_W-1:0] RECALL_CYC = `NSR_RECALL_CYC,
   parameter [`NSR_CNT_W-1:0] SOFT_CYC = `NSR_SOFT_CYC
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Supply monitor, high while the supply is above the trip level
   input wire vcc_above_trip,
   // Store/busy pin
   input wire store_busy_pin_in,
   output reg store_busy_pin_out_ff,
   output reg store_busy_pin_oe_n_ff,
   // Serial command decoder, one-cycle pulses
   input wire cmd_store,
   input wire cmd_recall,
   output reg serial_lock_ff,
   output reg busy_status_ff,
   // SRAM array side
   input wire sram_write,
   output reg sram_enable_ff,
   // Nonvolatile array side, levels for the whole copy
   output reg nv_store_ff,
   output reg nv_recall_ff
);

   // ****************************************************************
   // States and local constants
   // ****************************************************************
   localparam [`NSR_ST_W-1:0] ST_WAIT_VCC = 3'h0;
   localparam [`NSR_ST_W-1:0] ST_PUP = 3'h1;
   localparam [`NSR_ST_W-1:0] ST_IDLE = 3'h2;
   localparam [`NSR_ST_W-1:0] ST_GRACE = 3'h3;
   localparam [`NSR_ST_W-1:0] ST_STORE = 3'h4;
   localparam [`NSR_ST_W-1:0] ST_RECALL = 3'h5;
   localparam [`NSR_ST_W-1:0] ST_HIGH = 3'h6;

   localparam integer GRACE_I = `NSR_GRACE_CYC;
   localparam integer HIGH_I = `NSR_HIGH_CYC;
   localparam integer PULSE_I = `NSR_PULSE_CYC;
   localparam integer LAG_I = `NSR_PUP_LAG;
   localparam [`NSR_CNT_W-1:0] GRACE_CYC = GRACE_I[`NSR_CNT_W-1:0];
   localparam [`NSR_CNT_W-1:0] HIGH_CYC = HIGH_I[`NSR_CNT_W-1:0];
   localparam [`NSR_QUAL_W-1:0] PULSE_CYC = PULSE_I[`NSR_QUAL_W-1:0];
   // The synchroniser and the state entry eat into the restore budget,
   // so the power-up count is shortened by them to finish inside it.
   localparam [`NSR_CNT_W-1:0] PUP_LAG = LAG_I[`NSR_CNT_W-1:0];
   localparam [`NSR_CNT_W-1:0] CNT_ONE = 23'h00_0001;
   localparam [`NSR_CNT_W-1:0] CNT_ZERO = 23'h00_0000;
   localparam [`NSR_QUAL_W-1:0] QUAL_ONE = 3'h1;
   localparam [`NSR_QUAL_W-1:0] QUAL_ZERO = 3'h0;

   // ****************************************************************
   // Pin and supply synchronisation
   // ****************************************************************
   wire vcc_s;
   wire pin_low_s;
   wire pin_s;

   nsr_sync2 #(
      .W(1)
   ) u_sync_vcc (
      .clock(clock),
      .rst(rst),
      .async_in(vcc_above_trip),
      .sync_out(vcc_s)
   );

   // The pin goes through inverted, so that the cleared synchroniser
   // matches the idle pulled-up wire and no false request follows reset.
   nsr_sync2 #(
      .W(1)
   ) u_sync_pin (
      .clock(clock),
      .rst(rst),
      .async_in(~store_busy_pin_in),
      .sync_out(pin_low_s)
   );

   assign pin_s = ~pin_low_s;

   // ****************************************************************
   // State registers
   // ****************************************************************
   reg [`NSR_ST_W-1:0] state_ff;
   reg [`NSR_ST_W-1:0] nxt_state;
   reg [`NSR_CNT_W-1:0] cnt_ff;
   reg [`NSR_CNT_W-1:0] nxt_cnt;
   reg [`NSR_QUAL_W-1:0] qual_ff;
   reg [`NSR_QUAL_W-1:0] nxt_qual;
   reg op_store_ff;
   reg nxt_op_store;
   reg dirty_ff;
   reg nxt_dirty;
   reg armed_ff;
   reg nxt_armed;
   // Pin enable delayed by the depth of the synchroniser.
   reg oe_d1_ff;
   reg oe_d2_ff;
   reg nxt_pin_out;
   reg nxt_oe_n;
   reg nxt_busy;
   reg nxt_lock;
   reg nxt_sram_en;
   reg nxt_nv_store;
   reg nxt_nv_recall;

   // A low pin counts as a host request only once the pin was seen
   // high after our own drive ended, since the synchroniser lags by
   // two cycles and would otherwise echo our own low drive back.
   wire ext_low;
   wire hw_req;
   wire pin_ext_low;
   wire cnt_done;
   wire xfer_start;

   // ****************************************************************
   // Pin echo guard
   // ****************************************************************
   // Until our release has crossed the synchroniser the pin still shows
   // our own drive, so the wire is believed only two cycles after it.
   assign pin_ext_low = ~pin_s & store_busy_pin_oe_n_ff & oe_d1_ff & oe_d2_ff;
   assign ext_low = armed_ff & pin_ext_low;
   assign hw_req = ext_low & (qual_ff == PULSE_CYC - QUAL_ONE);
   assign cnt_done = (cnt_ff == CNT_ZERO);
   assign xfer_start = (state_ff == ST_GRACE) & cnt_done;

   // ****************************************************************
   // Transfer sequencer
   // ****************************************************************
   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_op_store = op_store_ff;
      nxt_qual = QUAL_ZERO;
      nxt_armed = armed_ff;
      case (state_ff)
         ST_WAIT_VCC: begin
            if (vcc_s) begin
               nxt_state = ST_PUP;
               nxt_cnt = PUP_CYC - PUP_LAG;
            end
         end
         ST_PUP: begin
            if (cnt_done) begin
               nxt_state = ST_IDLE;
            end else begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end
         end
         ST_IDLE: begin
            if (ext_low && !hw_req) begin
               nxt_qual = qual_ff + QUAL_ONE;
            end
            if (!vcc_s) begin
               if (dirty_ff) begin
                  nxt_state = ST_GRACE;
                  nxt_op_store = 1'b1;
                  nxt_cnt = GRACE_CYC - CNT_ONE;
               end else begin
                  nxt_state = ST_WAIT_VCC;
               end
            end else if (hw_req) begin
               nxt_armed = 1'b0;
               if (dirty_ff) begin
                  nxt_state = ST_GRACE;
                  nxt_op_store = 1'b1;
                  nxt_cnt = GRACE_CYC - CNT_ONE;
               end
               // Without a pending write the request is dropped and the
               // pin is never driven, so it answers at once.
            end else if (cmd_store || cmd_recall) begin
               nxt_state = ST_GRACE;
               nxt_op_store = cmd_store;
               nxt_cnt = GRACE_CYC - CNT_ONE;
            end
         end
         ST_GRACE: begin
            if (cnt_done) begin
               if (op_store_ff) begin
                  nxt_state = ST_STORE;
                  nxt_cnt = STORE_CYC - CNT_ONE;
               end else begin
                  nxt_state = ST_RECALL;
                  nxt_cnt = RECALL_CYC - CNT_ONE;
               end
            end else begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end
         end
         ST_STORE: begin
            if (cnt_done) begin
               nxt_state = ST_HIGH;
               nxt_cnt = HIGH_CYC - CNT_ONE;
            end else begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end
         end
         ST_RECALL: begin
            if (cnt_done) begin
               nxt_state = ST_IDLE;
            end else begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end
         end
         ST_HIGH: begin
            if (cnt_done) begin
               // A store that ends with the supply still low waits for the supply again.
               nxt_state = vcc_s ? ST_IDLE : ST_WAIT_VCC;
            end else begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end
         end
         default: begin
            nxt_state = ST_WAIT_VCC;
            nxt_cnt = CNT_ZERO;
         end
      endcase
      // Re-arm only after the pin is seen high while we do not drive it.
      if (!store_busy_pin_oe_n_ff) begin
         nxt_armed = 1'b0;
      end else if (pin_s) begin
         nxt_armed = 1'b1;
      end
   end

   // ****************************************************************
   // Write tracking and output decode
   // ****************************************************************
   always @* begin
      // A write landing in the cycle the flag clears still counts.
      nxt_dirty = (sram_write & sram_enable_ff) | (dirty_ff & ~xfer_start);
      // A host holding the pin keeps the SRAM shut even after its request
      // was used up or dropped, not only while it is being qualified.
      nxt_sram_en = vcc_s & ~pin_ext_low & ((nxt_state == ST_IDLE) |
                    (nxt_state == ST_GRACE));
      nxt_nv_store = (nxt_state == ST_STORE);
      nxt_nv_recall = (nxt_state == ST_RECALL) | (nxt_state == ST_PUP);
      nxt_busy = (nxt_state == ST_GRACE) | nxt_nv_store | nxt_nv_recall;
      nxt_lock = (nxt_state != ST_IDLE);
      nxt_oe_n = ~(nxt_nv_store | nxt_nv_recall | (nxt_state == ST_HIGH));
      nxt_pin_out = (nxt_state == ST_HIGH);
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always @(posedge clock) begin
      if (rst) begin
         state_ff <= ST_WAIT_VCC;
         cnt_ff <= CNT_ZERO;
         qual_ff <= QUAL_ZERO;
         op_store_ff <= 1'b0;
         dirty_ff <= 1'b0;
         armed_ff <= 1'b0;
         oe_d1_ff <= 1'b1;
         oe_d2_ff <= 1'b1;
         store_busy_pin_out_ff <= 1'b0;
         store_busy_pin_oe_n_ff <= 1'b1;
         serial_lock_ff <= 1'b1;
         busy_status_ff <= 1'b0;
         sram_enable_ff <= 1'b0;
         nv_store_ff <= 1'b0;
         nv_recall_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         qual_ff <= nxt_qual;
         op_store_ff <= nxt_op_store;
         dirty_ff <= nxt_dirty;
         armed_ff <= nxt_armed;
         oe_d1_ff <= store_busy_pin_oe_n_ff;
         oe_d2_ff <= oe_d1_ff;
         store_busy_pin_out_ff <= nxt_pin_out;
         store_busy_pin_oe_n_ff <= nxt_oe_n;
         serial_lock_ff <= nxt_lock;
         busy_status_ff <= nxt_busy;
         sram_enable_ff <= nxt_sram_en;
         nv_store_ff <= nxt_nv_store;
         nv_recall_ff <= nxt_nv_recall;
      end
   end

endmodule // nsr_store_recall_ctrl

`default_nettype wire

// ===== verilog/nsr_store_recall_map.vh
`ifndef NSR_STORE_RECALL_MAP_VH
`define NSR_STORE_RECALL_MAP_VH

// ****************************************************************
// Clock and timing figures
// ****************************************************************
`define NSR_CLK_NS 4
`define NSR_NS_PER_US 1000
`define NSR_NS_PER_MS 1000000

// Longest time the SRAM stays enabled after a transfer starts.
`define NSR_GRACE_NS 25
`define NSR_GRACE_CYC (`NSR_GRACE_NS / `NSR_CLK_NS)
// Least width of an external store request on the busy pin.
`define NSR_PULSE_NS 15
`define NSR_PULSE_CYC ((`NSR_PULSE_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
// Longest active high drive of the busy pin after a store.
`define NSR_HIGH_NS 500
`define NSR_HIGH_CYC (`NSR_HIGH_NS / `NSR_CLK_NS)
// Longest answer time of the pin when a store is skipped.
`define NSR_NOWRITE_NS 25
`define NSR_NOWRITE_CYC (`NSR_NOWRITE_NS / `NSR_CLK_NS)
// Longest latency before a serial command is acted upon.
`define NSR_SOFT_US 100
`define NSR_SOFT_CYC ((`NSR_SOFT_US * `NSR_NS_PER_US) / `NSR_CLK_NS)
// Store cycle, power-up restore and software recall durations.
`define NSR_STORE_MS 8
`define NSR_STORE_CYC ((`NSR_STORE_MS * `NSR_NS_PER_MS) / `NSR_CLK_NS)
`define NSR_PUP_MS 20
`define NSR_PUP_CYC ((`NSR_PUP_MS * `NSR_NS_PER_MS) / `NSR_CLK_NS)
// Cycles that the supply synchroniser and the state entry take at power up.
`define NSR_PUP_LAG 4
`define NSR_RECALL_US 200
`define NSR_RECALL_CYC ((`NSR_RECALL_US * `NSR_NS_PER_US) / `NSR_CLK_NS)

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define NSR_CNT_W 23
`define NSR_QUAL_W 3
`define NSR_ST_W 3
`define NSR_SYNC_RST 2'h0

`endif

// ===== verilog/nsr_sync2.v
`timescale 1ns/1ps
`default_nettype none

module nsr_sync2 #(
   parameter W = 2
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Asynchronous levels in, synchronised levels out
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);

   // ****************************************************************
   // Two flip-flop synchroniser
   // ****************************************************************
   // The first stage feeds only the second, to contain metastability.
   reg [W-1:0] meta_ff;

   always @(posedge clock) begin
      if (rst) begin
         meta_ff <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule // nsr_sync2

`default_nettype wire

// ===== bench/nsr_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks of the store and recall control
// ****
module nsr_ctrl_checker #(
   parameter int PUP_CYC = 60
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Inputs
   input wire logic vcc_above_trip,
   input wire logic store_busy_pin_in,
   input wire logic cmd_store,
   input wire logic cmd_recall,
   input wire logic sram_write,
   // Outputs
   input wire logic store_busy_pin_out_ff,
   input wire logic store_busy_pin_oe_n_ff,
   input wire logic serial_lock_ff,
   input wire logic busy_status_ff,
   input wire logic sram_enable_ff,
   input wire logic nv_store_ff,
   input wire logic nv_recall_ff
);
   localparam int PUP_MAX = PUP_CYC + 3;
   logic [7:0] hi_cnt_ff;
   logic xfer;
   assign xfer = nv_store_ff | nv_recall_ff;
   // A high drive left on would fight any host pulling the wire low.
   always_ff @(posedge clock) begin
      if (rst || store_busy_pin_oe_n_ff || !store_busy_pin_out_ff)
         hi_cnt_ff <= 8'h00;
      else
         hi_cnt_ff <= hi_cnt_ff + 8'h01;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence s_cmd_idle;
      (cmd_store || cmd_recall) && !serial_lock_ff && vcc_above_trip && store_busy_pin_in;
   endsequence
   sequence s_pin_held;
      !store_busy_pin_in [*5];
   endsequence
   AST_CMD_ACT: assert property (s_cmd_idle |-> ##[1:2] busy_status_ff && serial_lock_ff)
      else $error("command not acted on");
   AST_GRACE: assert property ($rose(busy_status_ff) |-> ##[0:6] !sram_enable_ff)
      else $error("grace too long");
   AST_XFER_SRAM: assert property (xfer |-> !sram_enable_ff)
      else $error("sram open in copy");
   AST_PIN_SRAM: assert property (s_pin_held |-> !sram_enable_ff)
      else $error("sram open with pin low");
   AST_XFER_PIN: assert property (xfer |-> !store_busy_pin_oe_n_ff && !store_busy_pin_out_ff)
      else $error("pin not low in copy");
   AST_XFER_BUSY: assert property (xfer |-> busy_status_ff)
      else $error("busy bit low in copy");
   AST_LOCK: assert property (busy_status_ff |-> serial_lock_ff)
      else $error("serial open while busy");
   AST_STORE_END: assert property ($fell(nv_store_ff) |-> store_busy_pin_out_ff)
      else $error("no high drive after store");
   AST_HIGH_MAX: assert property (hi_cnt_ff <= 8'h7D)
      else $error("high drive too long");
   AST_RESTORE: assert property ($rose(nv_recall_ff) |-> ##[1:PUP_MAX] !nv_recall_ff)
      else $error("recall too long");
endmodule // nsr_ctrl_checker
bind nsr_store_recall_ctrl nsr_ctrl_checker #(.PUP_CYC(PUP_CYC)) i_chk (
   .clock(clock), .rst(rst), .vcc_above_trip(vcc_above_trip),
   .store_busy_pin_in(store_busy_pin_in), .cmd_store(cmd_store), .cmd_recall(cmd_recall),
   .sram_write(sram_write), .store_busy_pin_out_ff(store_busy_pin_out_ff),
   .store_busy_pin_oe_n_ff(store_busy_pin_oe_n_ff), .serial_lock_ff(serial_lock_ff),
   .busy_status_ff(busy_status_ff), .sram_enable_ff(sram_enable_ff),
   .nv_store_ff(nv_store_ff), .nv_recall_ff(nv_recall_ff)
);
`default_nettype wire

// ===== bench/nsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host on the store/busy wire
// ****
module nsr_host_model (
   // Clock
   input wire logic clock,
   // Bench request and device drive
   input wire logic hold_low,
   input wire logic dev_out,
   input wire logic dev_oe_n,
   // Resolved wire
   output logic pin_level
);
   logic [2:0] width_ff = 3'h0;
   logic pull;
   // Requests wait until the device lets go of the wire.
   assign pull = hold_low & dev_oe_n;
   // A short request is stretched so that it always meets the least width.
   always @(posedge clock) begin
      if (pull)
         width_ff <= 3'h4;
      else if (width_ff != 3'h0)
         width_ff <= width_ff - 3'h1;
   end
   assign pin_level = (dev_oe_n | dev_out) & !pull & (width_ff == 3'h0);
endmodule // nsr_host_model
`default_nettype wire

// ===== bench/tb_nv_store_recall_control.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module tb_nv_store_recall_control;
   localparam int PUP_N = 60;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic vcc_above_trip = 1'b1;
   logic hold_low = 1'b0;
   logic cmd_store = 1'b0;
   logic cmd_recall = 1'b0;
   logic sram_write = 1'b0;
   wire logic store_busy_pin_in, store_busy_pin_out_ff, store_busy_pin_oe_n_ff, serial_lock_ff;
   wire logic busy_status_ff, sram_enable_ff, nv_store_ff, nv_recall_ff;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   always #2 clock = ~clock;
   // Short copy times keep the run brief.
   nsr_store_recall_ctrl #(.STORE_CYC(23'h00_0028), .PUP_CYC(23'h00_003C),
      .RECALL_CYC(23'h00_001E)) i_dut (
      .clock(clock), .rst(rst), .vcc_above_trip(vcc_above_trip),
      .store_busy_pin_in(store_busy_pin_in), .store_busy_pin_out_ff(store_busy_pin_out_ff),
      .store_busy_pin_oe_n_ff(store_busy_pin_oe_n_ff), .cmd_store(cmd_store),
      .cmd_recall(cmd_recall), .serial_lock_ff(serial_lock_ff), .busy_status_ff(busy_status_ff),
      .sram_write(sram_write), .sram_enable_ff(sram_enable_ff), .nv_store_ff(nv_store_ff),
      .nv_recall_ff(nv_recall_ff));
   nsr_host_model i_host (.clock(clock), .hold_low(hold_low), .dev_out(store_busy_pin_out_ff),
      .dev_oe_n(store_busy_pin_oe_n_ff), .pin_level(store_busy_pin_in));
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   function automatic logic pick(input int k);
      case (k)
         0: return serial_lock_ff;
         1: return nv_store_ff;
         2: return !store_busy_pin_oe_n_ff;
         default: return nv_recall_ff;
      endcase
   endfunction
   task automatic hold(input int k, output int n);
      n = 0;
      while (pick(k) === 1'b1 && n < 400) begin
         @(negedge clock);
         n++;
      end
   endtask
   task automatic t_restore;
      int n;
      cyc(4);
      chk({nv_recall_ff, store_busy_pin_oe_n_ff, busy_status_ff} === 3'h5, "restore");
      hold(0, n);
      chk(n + 4 <= PUP_N && sram_enable_ff === 1'b1, "restore time");
      $display("test restore done");
   endtask
   task automatic t_soft(input logic st);
      int n;
      cmd_store = st;
      cmd_recall = !st;
      cyc(1);
      cmd_store = 1'b0;
      cmd_recall = 1'b0;
      cyc(1);
      chk(busy_status_ff === 1'b1 && sram_enable_ff === 1'b1, "command");
      cmd_recall = 1'b1;
      cyc(1);
      cmd_recall = 1'b0;
      cyc(6);
      chk(!sram_enable_ff && (st ? nv_store_ff : nv_recall_ff) === 1'b1, "copy");
      hold(st ? 1 : 3, n);
      chk(store_busy_pin_out_ff === st, "pin drive after copy");
      hold(2, n);
      chk(n <= 125 && (n > 0) === st, "high drive");
      hold(0, n);
      cyc(3);
      chk(busy_status_ff === 1'b0 && sram_enable_ff === 1'b1, "locked command ran");
      $display("test soft %0d done", st);
   endtask
   task automatic t_pin(input logic wr);
      int n;
      sram_write = wr;
      cyc(1);
      sram_write = 1'b0;
      hold_low = 1'b1;
      cyc(6);
      chk(sram_enable_ff === 1'b0, "sram open");
      cyc(10);
      chk(nv_store_ff === wr && store_busy_pin_oe_n_ff === !wr, "pin store");
      sram_write = 1'b1;
      cyc(1);
      sram_write = 1'b0;
      hold_low = 1'b0;
      hold(1, n);
      hold(2, n);
      cyc(8);
      chk(sram_enable_ff === 1'b1 && serial_lock_ff === 1'b0, "no resume");
      $display("test pin %0d done", wr);
   endtask
   task automatic t_loss(input logic wr);
      int n;
      sram_write = wr;
      cyc(1);
      sram_write = 1'b0;
      vcc_above_trip = 1'b0;
      cyc(5);
      chk(sram_enable_ff === 1'b0, "sram open at low supply");
      cyc(8);
      chk(nv_store_ff === wr, "loss store");
      hold(1, n);
      hold(2, n);
      chk(busy_status_ff === 1'b0 && serial_lock_ff === 1'b1, "not waiting");
      vcc_above_trip = 1'b1;
      t_restore();
   endtask
   initial begin
      cyc(6);
      rst = 1'b0;
      t_restore();
      t_soft(1'b1);
      t_soft(1'b0);
      t_pin(1'b1);
      t_pin(1'b0);
      t_loss(1'b1);
      t_loss(1'b0);
      end_sim();
   end
endmodule // tb_nv_store_recall_control
`default_nettype wire
